// ===== common/tsch_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TSCH_MAP_SVH
`define TSCH_MAP_SVH

`define TSCH_ADDR_W      8
`define TSCH_CFG_OFS     8'h00
`define TSCH_STAT_OFS    8'h04
`define TSCH_CNT_OFS     8'h08

`define TSCH_CFG_RST     32'h0000_0991
`define TSCH_CFG_MASK    32'h007f_0ff3
`define TSCH_F_SOC       0
`define TSCH_F_NOTEL     1
`define TSCH_F_ON_LO     4
`define TSCH_F_ON_HI     7
`define TSCH_F_OFF_LO    8
`define TSCH_F_OFF_HI    11
`define TSCH_F_CYC_LO    16
`define TSCH_F_CYC_HI    22

`define TSCH_S_OBJ       0
`define TSCH_S_ONP       1
`define TSCH_S_OFFP      2
`define TSCH_S_RAW       3

`define TSCH_CYC_MAX     7'h78
`define TSCH_CYC_STEP_S  11'h00a

`define TSCH_SEC_NS      1000000000
`define TSCH_CLK_NS      10
`define TSCH_SUB_W       27
`define TSCH_SEC_W       12
`define TSCH_CSEC_W      11
`define TSCH_CNT_W       16

`define TSCH_RESP_OK     2'h0
`define TSCH_RESP_ERR    2'h2

`define TSCH_D_NONE      12'h000
`define TSCH_D_1S        12'h001
`define TSCH_D_3S        12'h003
`define TSCH_D_5S        12'h005
`define TSCH_D_10S       12'h00a
`define TSCH_D_15S       12'h00f
`define TSCH_D_30S       12'h01e
`define TSCH_D_1M        12'h03c
`define TSCH_D_3M        12'h0b4
`define TSCH_D_5M        12'h12c
`define TSCH_D_10M       12'h258
`define TSCH_D_15M       12'h384
`define TSCH_D_30M       12'h708
`define TSCH_D_60M       12'he10

`endif

// ===== common/tsch_pkg.sv
// Types and decode functions of the threshold telegram scheduler
`default_nettype none
`include "tsch_map.svh"

package tsch_pkg;

    typedef enum logic {AX_IDLE, AX_RESP} tsch_axi_t;
    typedef enum logic {DL_IDLE, DL_RUN}  tsch_dly_t;
    typedef logic [3:0]                   tsch_sel_t;

    function automatic logic [`TSCH_SEC_W-1:0] tschDelaySec(
        input tsch_sel_t sel
    );
        case (sel)
            4'h0:    return `TSCH_D_NONE;
            4'h1:    return `TSCH_D_1S;
            4'h2:    return `TSCH_D_3S;
            4'h3:    return `TSCH_D_5S;
            4'h4:    return `TSCH_D_10S;
            4'h5:    return `TSCH_D_15S;
            4'h6:    return `TSCH_D_30S;
            4'h7:    return `TSCH_D_1M;
            4'h8:    return `TSCH_D_3M;
            4'h9:    return `TSCH_D_5M;
            4'ha:    return `TSCH_D_10M;
            4'hb:    return `TSCH_D_15M;
            4'hc:    return `TSCH_D_30M;
            default: return `TSCH_D_60M;
        endcase
    endfunction: tschDelaySec

    function automatic logic [`TSCH_CSEC_W-1:0] tschCycleSec(
        input logic [6:0] setting
    );
        logic [6:0] s;
        s = (setting > `TSCH_CYC_MAX) ? `TSCH_CYC_MAX : setting;
        return `TSCH_CSEC_W'(s) * `TSCH_CYC_STEP_S;
    endfunction: tschCycleSec

    function automatic logic tschHit(
        input logic [`TSCH_ADDR_W-1:0] addr,
        input logic [`TSCH_ADDR_W-1:0] ofs
    );
        return addr[`TSCH_ADDR_W-1:2] == ofs[`TSCH_ADDR_W-1:2];
    endfunction: tschHit

endpackage: tsch_pkg
`default_nettype wire

// ===== logic/tsch_cycle.sv
// Cyclic repeat timer of the output object
`timescale 1ns/10ps
`default_nettype none
`include "tsch_map.svh"

module tsch_cycle
    import tsch_pkg::*;
#(
    parameter int unsigned CYCLES_PER_SEC = `TSCH_SEC_NS / `TSCH_CLK_NS
)(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [6:0] setting,
    output logic            fire
);

    typedef struct packed {
        logic [`TSCH_SUB_W-1:0]  subCnt;
        logic [`TSCH_CSEC_W-1:0] secCnt;
        logic                    fire;
    } tsch_cyc_st_t;

    localparam logic [`TSCH_SUB_W-1:0] SUB_LAST =
        `TSCH_SUB_W'(CYCLES_PER_SEC - 1);

    tsch_cyc_st_t            st_reg;
    tsch_cyc_st_t            st_next;
    logic [`TSCH_CSEC_W-1:0] period;
    logic [`TSCH_CSEC_W-1:0] secInc;

    always_comb
    begin
        period       = tschCycleSec(setting);
        secInc       = st_reg.secCnt + `TSCH_CSEC_W'(1);
        st_next      = st_reg;
        st_next.fire = 1'b0;
        if (period == '0)
        begin
            st_next.subCnt = '0;
            st_next.secCnt = '0;
        end
        else if (st_reg.subCnt == SUB_LAST)
        begin
            st_next.subCnt = '0;
            // Runs free of change telegrams; >= catches a shortened setting
            if (secInc >= period)
            begin
                st_next.secCnt = '0;
                st_next.fire   = 1'b1;
            end
            else
            begin
                st_next.secCnt = secInc;
            end
        end
        else
        begin
            st_next.subCnt = st_reg.subCnt + `TSCH_SUB_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign fire = st_reg.fire;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    cycle_off_a: assert property (
        setting == 7'h00 |=> !fire)
        else $error("cyclic fire with interval zero");

    cycle_spacing_a: assert property (
        fire |=> !fire [*8])
        else $error("cyclic fires too close together");

endmodule: tsch_cycle
`default_nettype wire

// ===== logic/tsch_delay.sv
// Switch-on and switch-off delay stage of the output object
`timescale 1ns/10ps
`default_nettype none
`include "tsch_map.svh"

module tsch_delay
    import tsch_pkg::*;
#(
    parameter int unsigned CYCLES_PER_SEC = `TSCH_SEC_NS / `TSCH_CLK_NS
)(
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   rawState,
    input  wire logic [`TSCH_SEC_W-1:0] onSec,
    input  wire logic [`TSCH_SEC_W-1:0] offSec,
    output logic                        objValue,
    output logic                        changed,
    output logic                        onPending,
    output logic                        offPending
);

    typedef struct packed {
        tsch_dly_t              state;
        logic                   objValue;
        logic                   changed;
        logic [`TSCH_SUB_W-1:0] subCnt;
        logic [`TSCH_SEC_W-1:0] secCnt;
    } tsch_dly_st_t;

    localparam logic [`TSCH_SUB_W-1:0] SUB_LAST =
        `TSCH_SUB_W'(CYCLES_PER_SEC - 1);

    tsch_dly_st_t           st_reg;
    tsch_dly_st_t           st_next;
    logic [`TSCH_SEC_W-1:0] dly;
    logic [`TSCH_SEC_W-1:0] secInc;

    always_comb
    begin
        // Direction follows the applied value, not the raw input
        dly             = st_reg.objValue ? offSec : onSec;
        secInc          = st_reg.secCnt + `TSCH_SEC_W'(1);
        st_next         = st_reg;
        st_next.changed = 1'b0;
        case (st_reg.state)
            DL_IDLE:
            begin
                if (rawState != st_reg.objValue)
                begin
                    if (dly == `TSCH_D_NONE)
                    begin
                        st_next.objValue = rawState;
                        st_next.changed  = 1'b1;
                    end
                    else
                    begin
                        // Own prescaler restarts so a full delay elapses
                        st_next.state  = DL_RUN;
                        st_next.subCnt = '0;
                        st_next.secCnt = '0;
                    end
                end
            end
            DL_RUN:
            begin
                if (rawState == st_reg.objValue)
                begin
                    st_next.state = DL_IDLE;
                end
                else if (st_reg.subCnt == SUB_LAST)
                begin
                    st_next.subCnt = '0;
                    if (secInc >= dly)
                    begin
                        st_next.objValue = rawState;
                        st_next.changed  = 1'b1;
                        st_next.state    = DL_IDLE;
                    end
                    else
                    begin
                        st_next.secCnt = secInc;
                    end
                end
                else
                begin
                    st_next.subCnt = st_reg.subCnt + `TSCH_SUB_W'(1);
                end
            end
            default:
            begin
                st_next.state = DL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '{state: DL_IDLE, default: '0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign objValue   = st_reg.objValue;
    assign changed    = st_reg.changed;
    assign onPending  = (st_reg.state == DL_RUN) && !st_reg.objValue;
    assign offPending = (st_reg.state == DL_RUN) && st_reg.objValue;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    on_delay_a: assert property (
        $rose(objValue) && $past(onSec) != `TSCH_D_NONE
        |-> $past(st_reg.state) == DL_RUN)
        else $error("output rose without a running switch-on delay");

    pending_cancel_a: assert property (
        st_reg.state == DL_RUN && rawState == st_reg.objValue
        |=> st_reg.state == DL_IDLE && $stable(objValue))
        else $error("pending change not cancelled");

    hold_value_a: assert property (
        st_reg.state == DL_RUN && st_next.state == DL_RUN
        |=> $stable(objValue) && !changed)
        else $error("output object moved while delay runs");

endmodule: tsch_delay
`default_nettype wire

// ===== logic/tsch_top.sv
// Threshold telegram scheduler with its AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "tsch_map.svh"

module tsch_top
    import tsch_pkg::*;
#(
    parameter int unsigned CYCLES_PER_SEC = `TSCH_SEC_NS / `TSCH_CLK_NS
)(
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic [`TSCH_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`TSCH_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    thresholdRaw,
    input  wire logic                    conditionMet,
    output logic                         objectValue,
    output logic                         telegramStrobe,
    output logic                         telegramValue,
    output logic                         telegramCyclic
);

    typedef struct packed {
        tsch_axi_t               wrState;
        logic                    awHave;
        logic [`TSCH_ADDR_W-1:0] awAddr;
        logic                    wHave;
        logic [31:0]             wData;
        logic [3:0]              wStrb;
        logic [1:0]              bResp;
        tsch_axi_t               rdState;
        logic [31:0]             rData;
        logic [1:0]              rResp;
        logic [31:0]             cfg;
        logic                    telStrobe;
        logic                    telValue;
        logic                    telCyclic;
        logic [`TSCH_CNT_W-1:0]  telCount;
    } tsch_top_st_t;

    tsch_top_st_t st_reg;
    tsch_top_st_t st_next;
    logic         objValue;
    logic         changed;
    logic         onPending;
    logic         offPending;
    logic         cycleFire;
    logic         chgSend;
    logic         cycSend;
    logic [31:0]  statWord;
    logic [31:0]  newCfg;
    logic [6:0]   cycSet;

    tsch_delay #(
        .CYCLES_PER_SEC (CYCLES_PER_SEC)
    ) u_delay (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .rawState   (thresholdRaw),
        .onSec      (tschDelaySec(st_reg.cfg[`TSCH_F_ON_HI:`TSCH_F_ON_LO])),
        .offSec     (tschDelaySec(st_reg.cfg[`TSCH_F_OFF_HI:`TSCH_F_OFF_LO])),
        .objValue   (objValue),
        .changed    (changed),
        .onPending  (onPending),
        .offPending (offPending)
    );

    tsch_cycle #(
        .CYCLES_PER_SEC (CYCLES_PER_SEC)
    ) u_cycle (
        .clk     (clk),
        .sys_rst (sys_rst),
        .setting (st_reg.cfg[`TSCH_F_CYC_HI:`TSCH_F_CYC_LO]),
        .fire    (cycleFire)
    );

    assign s_axi_awready = (st_reg.wrState == AX_IDLE) && !st_reg.awHave;
    assign s_axi_wready  = (st_reg.wrState == AX_IDLE) && !st_reg.wHave;
    assign s_axi_bvalid  = (st_reg.wrState == AX_RESP);
    assign s_axi_bresp   = st_reg.bResp;
    assign s_axi_arready = (st_reg.rdState == AX_IDLE);
    assign s_axi_rvalid  = (st_reg.rdState == AX_RESP);
    assign s_axi_rdata   = st_reg.rData;
    assign s_axi_rresp   = st_reg.rResp;

    always_comb
    begin
        st_next  = st_reg;
        statWord = '0;
        statWord[`TSCH_S_OBJ]  = objValue;
        statWord[`TSCH_S_ONP]  = onPending;
        statWord[`TSCH_S_OFFP] = offPending;
        statWord[`TSCH_S_RAW]  = thresholdRaw;
        newCfg = st_reg.cfg;
        cycSet = '0;

        // Write channel: address and data taken in either order
        if (st_reg.wrState == AX_IDLE)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                st_next.awHave = 1'b1;
                st_next.awAddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                st_next.wHave = 1'b1;
                st_next.wData = s_axi_wdata;
                st_next.wStrb = s_axi_wstrb;
            end
            if (st_next.awHave && st_next.wHave)
            begin
                st_next.awHave  = 1'b0;
                st_next.wHave   = 1'b0;
                st_next.wrState = AX_RESP;
                st_next.bResp   = `TSCH_RESP_OK;
                if (tschHit(st_next.awAddr, `TSCH_CFG_OFS))
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if (st_next.wStrb[b])
                        begin
                            newCfg[b*8 +: 8] = st_next.wData[b*8 +: 8];
                        end
                    end
                    newCfg = newCfg & `TSCH_CFG_MASK;
                    cycSet = newCfg[`TSCH_F_CYC_HI:`TSCH_F_CYC_LO];
                    // Out-of-range interval clamps to the top setting
                    if (cycSet > `TSCH_CYC_MAX)
                    begin
                        newCfg[`TSCH_F_CYC_HI:`TSCH_F_CYC_LO] = `TSCH_CYC_MAX;
                    end
                    st_next.cfg = newCfg;
                end
                else if (!tschHit(st_next.awAddr, `TSCH_STAT_OFS) &&
                         !tschHit(st_next.awAddr, `TSCH_CNT_OFS))
                begin
                    st_next.bResp = `TSCH_RESP_ERR;
                end
            end
        end
        else if (s_axi_bready)
        begin
            st_next.wrState = AX_IDLE;
        end

        // Read channel
        if (st_reg.rdState == AX_IDLE)
        begin
            if (s_axi_arvalid)
            begin
                st_next.rdState = AX_RESP;
                st_next.rResp   = `TSCH_RESP_OK;
                if (tschHit(s_axi_araddr, `TSCH_CFG_OFS))
                begin
                    st_next.rData = st_reg.cfg;
                end
                else if (tschHit(s_axi_araddr, `TSCH_STAT_OFS))
                begin
                    st_next.rData = statWord;
                end
                else if (tschHit(s_axi_araddr, `TSCH_CNT_OFS))
                begin
                    st_next.rData = 32'(st_reg.telCount);
                end
                else
                begin
                    st_next.rData = '0;
                    st_next.rResp = `TSCH_RESP_ERR;
                end
            end
        end
        else if (s_axi_rready)
        begin
            st_next.rdState = AX_IDLE;
        end

        // Telegram scheduling; a coinciding change and cycle send once
        chgSend = changed && st_reg.cfg[`TSCH_F_SOC];
        cycSend = cycleFire &&
                  !(st_reg.cfg[`TSCH_F_NOTEL] && conditionMet);
        st_next.telStrobe = chgSend || cycSend;
        if (st_next.telStrobe)
        begin
            // Delayed value stays old until the delay stage applies it
            st_next.telValue  = objValue;
            st_next.telCyclic = !chgSend;
            st_next.telCount  = st_reg.telCount + `TSCH_CNT_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '{wrState: AX_IDLE, rdState: AX_IDLE,
                        cfg: `TSCH_CFG_RST, default: '0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign objectValue    = objValue;
    assign telegramStrobe = st_reg.telStrobe;
    assign telegramValue  = st_reg.telValue;
    assign telegramCyclic = st_reg.telCyclic;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    bvalid_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");

    rvalid_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");

    change_gate_a: assert property (
        telegramStrobe && !telegramCyclic
        |-> $past(st_reg.cfg[`TSCH_F_SOC]) && $past(changed))
        else $error("change telegram while change sending is off");

    cyclic_suppress_a: assert property (
        telegramStrobe && telegramCyclic
        |-> !$past(st_reg.cfg[`TSCH_F_NOTEL] && conditionMet))
        else $error("cyclic telegram under no-telegram condition");

    sent_value_a: assert property (
        telegramStrobe |-> telegramValue == $past(objValue))
        else $error("telegram carries other than the applied value");

    never_send_a: assert property (
        !st_reg.cfg[`TSCH_F_SOC] &&
        st_reg.cfg[`TSCH_F_CYC_HI:`TSCH_F_CYC_LO] == 7'h00 &&
        $past(!st_reg.cfg[`TSCH_F_SOC] &&
              st_reg.cfg[`TSCH_F_CYC_HI:`TSCH_F_CYC_LO] == 7'h00)
        |=> !telegramStrobe)
        else $error("telegram sent with both sending modes off");

endmodule: tsch_top
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench of the threshold telegram scheduler
`timescale 1ns/10ps
`default_nettype none
`include "tsch_map.svh"

module tb_top;
    import tsch_pkg::*;
    // Few cycles a second keep the 60 min delay inside the run
    localparam int CPS = 4;
    int          secTab [14] = '{0, 1, 3, 5, 10, 15, 30, 60, 180, 300,
                                 600, 900, 1800, 3600};
    logic        clk = 1'h0;
    logic        sysRst = 1'h1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'h0;
    logic        wvalid = 1'h0;
    logic        bready = 1'h0;
    logic        arvalid = 1'h0;
    logic        rready = 1'h0;
    logic        raw = 1'h0;
    logic        cond = 1'h0;
    logic        objPrev = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        obj, tStb, tVal, tCyc, rxLast;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          rxCount, rxCyc;
    int          failCount = 0;
    int          checks = 0;
    int          seed = 32'hb0e8;
    int          expTel = 0, expCyc = 0, period = 0, lastCyc = -1, cyc = 0;

    always #5 clk = ~clk;

    tsch_top #(.CYCLES_PER_SEC(CPS)) u_tsch_top (
        .clk(clk), .sys_rst(sysRst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .thresholdRaw(raw), .conditionMet(cond), .objectValue(obj),
        .telegramStrobe(tStb), .telegramValue(tVal),
        .telegramCyclic(tCyc)
    );

    tsch_bus_rx u_tsch_bus_rx (
        .clk(clk), .sys_rst(sysRst), .strobe(tStb), .value(tVal),
        .cyclic(tCyc), .rxCount(rxCount), .rxCyc(rxCyc), .rxLast(rxLast)
    );

    task automatic chkBit(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp)
        begin
            failCount++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask: chkBit

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp,
                           input string m);
        checks++;
        if (got !== exp)
        begin
            failCount++;
            $display("wrong value at %0t: %s %h", $time, m, got);
        end
    endtask: chkWord

    task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'h0;
        @(posedge clk);
    endtask: axiWr

    task automatic axiRd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'h0;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge clk);
    endtask: axiRd

    task automatic setCfg(input int soc, nt, onSel, offSel, cy);
        logic [1:0] r;
        axiWr(`TSCH_CFG_OFS, 32'(soc + nt * 2 + onSel * 16 + offSel * 256
              + cy * 65536), r);
        chkWord(32'(r), 32'h0, "write response");
        period = (cy > `TSCH_CYC_MAX ? `TSCH_CYC_MAX : cy) * 10 * CPS;
        lastCyc = -1;
    endtask: setCfg

    // Latency counts from the edge raw is driven until obj is seen
    task automatic flip(input logic v, output int lat);
        raw <= v;
        lat = 0;
        do
        begin
            @(posedge clk);
            lat++;
        end
        while (obj !== v);
    endtask: flip

    task automatic chkLat(input int lat, input int sec);
        chkBit(1'(lat >= sec * CPS + 2 && lat <= sec * CPS + 4), 1'h1,
               "delay length");
    endtask: chkLat

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask: conclude

    // Telegrams seen while obj is steady carry the applied value; cyclic ones keep period
    always @(posedge clk)
    begin
        cyc++;
        if (!sysRst && tStb)
        begin
            if (obj === objPrev)
                chkBit(tVal, obj, "telegram value");
            if (tCyc && lastCyc >= 0)
                chkWord(32'(cyc - lastCyc), 32'(period), "period");
            if (tCyc)
                lastCyc = cyc;
        end
        objPrev <= obj;
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        failCount++;
        conclude();
    end

    initial
    begin
        int lat;
        logic [31:0] d;
        logic [1:0] r;
        repeat (3) @(posedge clk);
        sysRst <= 1'h0;
        @(posedge clk);
        axiRd(`TSCH_CFG_OFS, d, r);
        chkWord(d, 32'h0000_0991, "reset config");
        axiRd(8'h0c, d, r);
        chkWord(32'(r), 32'h2, "unmapped read");
        axiWr(8'h0c, 32'h0, r);
        chkWord(32'(r), 32'h2, "unmapped write");
        setCfg(1, 0, 0, 0, 127);
        axiRd(`TSCH_CFG_OFS, d, r);
        chkWord(d, 32'h0078_0001, "interval clamp");
        for (int s = 0; s < 14; s++)
        begin
            setCfg(1, 0, 0, s, 0);
            flip(1'h1, lat);
            flip(1'h0, lat);
            chkLat(lat, secTab[s]);
            expTel += 2;
        end
        for (int v = 1; v >= 0; v--)
        begin
            setCfg(1, 0, 2, 2, 0);
            raw <= v[0];
            // Status read inside the 3 s delay, so the cancel stays early
            repeat (2) @(posedge clk);
            axiRd(`TSCH_STAT_OFS, d, r);
            chkWord(d, v[0] ? 32'ha : 32'h5, "pending status");
            repeat (1 + $unsigned($random(seed)) % 6) @(posedge clk);
            raw <= ~v[0];
            repeat (30) @(posedge clk);
            chkBit(obj, ~v[0], "cancelled change");
            flip(v[0], lat);
            expTel++;
        end
        setCfg(1, 0, 6, 6, 1);
        repeat (20) @(posedge clk);
        flip(1'h1, lat);
        chkLat(lat, 30);
        repeat (20) @(posedge clk);
        flip(1'h0, lat);
        repeat (20) @(posedge clk);
        expTel += 9;
        expCyc += 7;
        chkWord(32'(rxCyc), 32'(expCyc), "cyclic during delays");
        setCfg(1, 0, 0, 0, 0);
        setCfg(0, 0, 0, 0, 1);
        flip(1'h1, lat);
        flip(1'h0, lat);
        repeat (186) @(posedge clk);
        expTel += 4;
        expCyc += 4;
        chkWord(32'(rxCount), 32'(expTel), "no change send");
        chkWord(32'(rxCyc), 32'(expCyc), "cyclic alone");
        setCfg(0, 0, 0, 0, 0);
        cond <= 1'h1;
        setCfg(0, 1, 0, 0, 1);
        repeat (190) @(posedge clk);
        chkWord(32'(rxCyc), 32'(expCyc), "suppressed");
        cond <= 1'h0;
        lastCyc = -1;
        repeat (100) @(posedge clk);
        expTel += 3;
        expCyc += 3;
        chkWord(32'(rxCyc), 32'(expCyc), "resumed");
        setCfg(0, 0, 0, 0, 0);
        flip(1'h1, lat);
        flip(1'h0, lat);
        repeat (100) @(posedge clk);
        chkWord(32'(rxCount), 32'(expTel), "never sent");
        axiRd(`TSCH_CNT_OFS, d, r);
        chkWord(d, 32'(expTel), "telegram count");
        chkBit(rxLast, obj, "last value");
        conclude();
    end
endmodule: tb_top
`default_nettype wire

// ===== tb/tsch_bus_rx.sv
// Bus-side receiver model counting telegrams of the output object
`timescale 1ns/10ps
`default_nettype none

module tsch_bus_rx (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic strobe,
    input  wire logic value,
    input  wire logic cyclic,
    output var int    rxCount,
    output var int    rxCyc,
    output logic      rxLast
);
    // Receivers never refuse, so every strobe is one telegram
    always @(posedge clk)
        if (sys_rst)
        begin
            rxCount <= 0;
            rxCyc <= 0;
            rxLast <= 1'h0;
        end
        else if (strobe)
        begin
            rxCount <= rxCount + 1;
            rxCyc <= rxCyc + int'(cyclic);
            rxLast <= value;
        end
endmodule: tsch_bus_rx
`default_nettype wire
